// ==== ifl_pkg.sv ====
// constants and register map of the input FIFO and parity counters
// Behaviour
// - saturating count of rising-sample parity errors
// - saturating count of falling-sample parity errors
// - both counts read-only, zero after reset
// - buffer holds exactly eight slots
// - both pointers wrap from seven to zero
// - depth is read-to-write distance, equals latency
// - sync reset forces a nonzero predefined depth
// - predefined depth defaults to four slots
// - latency undefined until a sync reset
// - read side runs on clock divided by two
// - sync reset also forces the divider phase to zero
// - write and read sides reset by separate references
// - clear bit zeroes both error counts
// - sticky flags show any parity error seen
`default_nettype none
package ifl_pkg;
    localparam int          SLOTS          = 8;
    localparam int          PTR_W          = 3;
    localparam int          WORD_W         = 16;
    localparam int          CNT_W          = 8;
    localparam int          REG_W          = 8;
    localparam int          SYNC_W         = 20;
    // register offsets
    localparam logic [7:0]  OFS_PAR_CTRL   = 8'h6A;
    localparam logic [7:0]  OFS_RISE_CNT   = 8'h6B;
    localparam logic [7:0]  OFS_FALL_CNT   = 8'h6C;
    localparam logic [7:0]  OFS_IRQ_STAT   = 8'h70;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h71;
    localparam logic [7:0]  OFS_FIFO_STAT  = 8'h72;
    localparam logic [7:0]  OFS_DEPTH_CFG  = 8'h73;
    localparam logic [7:0]  OFS_REVISION   = 8'h7F;
    // control field positions
    localparam int          BIT_PAR_EN     = 7;
    localparam int          BIT_PAR_EVEN   = 6;
    localparam int          BIT_PAR_CLR    = 5;
    localparam int          BIT_FALL_FLAG  = 1;
    localparam int          BIT_RISE_FLAG  = 0;
    // status and mask field positions
    localparam int          IRQ_N          = 4;
    localparam int          IRQ_RISE       = 0;
    localparam int          IRQ_FALL       = 1;
    localparam int          IRQ_FRAME      = 2;
    localparam int          IRQ_SYNC       = 3;
    // fifo status field positions
    localparam int          BIT_LOCKED     = 7;
    localparam int          BIT_FRAMESEEN  = 6;
    // synchroniser slice positions
    localparam int          SY_WCLK        = 19;
    localparam int          SY_FRAME       = 18;
    localparam int          SY_SYNC        = 17;
    localparam int          SY_PAR         = 16;
    // reset values and count ceiling
    localparam logic [PTR_W-1:0] DEPTH_RST = 3'h4;
    localparam logic [7:0]  CTRL_RST       = 8'h00;
    localparam logic [7:0]  CNT_RST        = 8'h00;
    localparam logic [7:0]  MASK_RST       = 8'h00;
    localparam logic [7:0]  CNT_MAX        = 8'hFF;
    // arbitrary neutral identity value
    localparam logic [7:0]  REVISION_DEF   = 8'h5A;
endpackage : ifl_pkg
`default_nettype wire

// ==== ifl_slot_ram.sv ====
// eight-slot word store with registered read data
`timescale 1ns/1ps
`default_nettype none
module ifl_slot_ram
    import ifl_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               ce,
    input  wire logic               wrEn,
    input  wire logic [PTR_W-1:0]   wrAddr,
    input  wire logic [WORD_W-1:0]  wrData,
    input  wire logic               rdEn,
    input  wire logic [PTR_W-1:0]   rdAddr,
    output logic      [WORD_W-1:0]  rdData_q
);
    logic [WORD_W-1:0] mem [SLOTS];
    logic [WORD_W-1:0] rdData_d;

    always_comb
    begin
        rdData_d = rdData_q;
        if (ce && rdEn)
            rdData_d = mem[rdAddr];
    end

    // no reset on storage: slot contents are meaningless until written
    always_ff @(posedge clk_sys)
    begin
        if (ce && wrEn)
            mem[wrAddr] <= wrData;
        rdData_q <= rdData_d;
    end
endmodule // ifl_slot_ram
`default_nettype wire

// ==== ifl_sat_counter.sv ====
// eight-bit saturating error counter with clear
`timescale 1ns/1ps
`default_nettype none
module ifl_sat_counter
    import ifl_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    input  wire logic               ce,
    input  wire logic               clear,
    input  wire logic               hit,
    output logic      [CNT_W-1:0]   count_q
);
    logic [CNT_W-1:0] count_d;

    always_comb
    begin
        count_d = count_q;
        // clear zeroes; a hit in the same cycle still counts
        if (clear)
            count_d = hit ? 8'h01 : CNT_RST;
        else if (hit && count_q != CNT_MAX)
            count_d = count_q + 8'h01;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            count_q <= CNT_RST;
        else if (ce)
            count_q <= count_d;
    end
endmodule // ifl_sat_counter
`default_nettype wire

// ==== ifl_input_fifo.sv ====
// input FIFO with fixed-latency sync resets and parity error counting
`timescale 1ns/1ps
`default_nettype none
module ifl_input_fifo
    import ifl_pkg::*;
#(
    parameter logic [7:0]           REVISION = REVISION_DEF
)
(
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    input  wire logic               ce,
    input  wire logic               inputWordClock,
    input  wire logic [WORD_W-1:0]  dataIn,
    input  wire logic               parityIn,
    input  wire logic               frameRef,
    input  wire logic               syncRef,
    input  wire logic [7:0]         regAddr,
    input  wire logic [REG_W-1:0]   regWrData,
    input  wire logic               regWr,
    input  wire logic               regRd,
    output logic      [REG_W-1:0]   regRdData_q,
    output logic      [WORD_W-1:0]  sampleOut,
    output logic                    sampleValid_q,
    output logic                    readTick,
    output logic                    irq
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [SYNC_W-1:0] sync1_q, sync2_q, sync3_q;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end
        else if (ce)
        begin
            sync1_q <= {inputWordClock, frameRef, syncRef, parityIn, dataIn};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    logic wclkRise, wclkFall, frameEdge, syncEdge;
    assign wclkRise  = sync2_q[SY_WCLK] & ~sync3_q[SY_WCLK];
    assign wclkFall  = ~sync2_q[SY_WCLK] & sync3_q[SY_WCLK];
    assign frameEdge = sync2_q[SY_FRAME] & ~sync3_q[SY_FRAME];
    assign syncEdge  = sync2_q[SY_SYNC] & ~sync3_q[SY_SYNC];

    ////////////////////////////////////////////////////////////////////////////
    // parity check
    function automatic logic parity_fail(input logic [WORD_W-1:0] w, input logic p, input logic even);
        parity_fail = (^{w, p}) ^ ~even;
    endfunction

    logic [7:0] ctrl_q, ctrl_d;
    logic       riseErr, fallErr, wordErr, parClear;

    // rising-clock samples sit at positions 0 and 2, falling at 1 and 3
    assign wordErr = ctrl_q[BIT_PAR_EN] &
                     parity_fail(sync2_q[WORD_W-1:0], sync2_q[SY_PAR], ctrl_q[BIT_PAR_EVEN]);
    assign riseErr = wclkRise & wordErr;
    assign fallErr = wclkFall & wordErr;
    assign parClear = regWr && regAddr == OFS_PAR_CTRL && regWrData[BIT_PAR_CLR];

    logic [CNT_W-1:0] riseCount, fallCount;

    ifl_sat_counter u_rise_cnt (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .ce      (ce),
        .clear   (parClear),
        .hit     (riseErr),
        .count_q (riseCount)
    );

    ifl_sat_counter u_fall_cnt (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .ce      (ce),
        .clear   (parClear),
        .hit     (fallErr),
        .count_q (fallCount)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pointers, divider and latency control
    logic [PTR_W-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d, depthCfg_q, depthCfg_d, fill;
    logic             phase_q, phase_d, locked_q, locked_d, frameSeen_q, frameSeen_d, wrEn;

    assign wrEn     = (wclkRise | wclkFall) & ~frameEdge;
    // read side ticks on every other clock
    assign readTick = phase_q;
    assign fill     = wrPtr_q - rdPtr_q;

    always_comb
    begin
        wrPtr_d     = wrPtr_q;
        rdPtr_d     = rdPtr_q;
        phase_d     = ~phase_q;
        locked_d    = locked_q;
        frameSeen_d = frameSeen_q | frameEdge;
        depthCfg_d  = depthCfg_q;
        // zero depth refused, keeps the old one
        if (regWr && regAddr == OFS_DEPTH_CFG && regWrData[PTR_W-1:0] != 3'h0)
            depthCfg_d = regWrData[PTR_W-1:0];
        if (frameEdge)
            wrPtr_d = 3'h0;
        // one slot per captured word, natural wrap
        else if (wrEn)
            wrPtr_d = wrPtr_q + 3'h1;
        if (syncEdge)
        begin
            rdPtr_d  = wrPtr_d - depthCfg_q;
            phase_d  = 1'b0;
            locked_d = frameSeen_q | frameEdge;
        end
        else if (phase_q)
            rdPtr_d = rdPtr_q + 3'h1;
    end

    always_ff @(posedge clk_sys)
    begin
        // pointers start at an unaligned state; not locked
        if (!reset_n)
        begin
            wrPtr_q     <= 3'h0;
            rdPtr_q     <= 3'h0;
            phase_q     <= 1'b0;
            locked_q    <= 1'b0;
            frameSeen_q <= 1'b0;
            depthCfg_q  <= DEPTH_RST;
        end
        else if (ce)
        begin
            wrPtr_q     <= wrPtr_d;
            rdPtr_q     <= rdPtr_d;
            phase_q     <= phase_d;
            locked_q    <= locked_d;
            frameSeen_q <= frameSeen_d;
            depthCfg_q  <= depthCfg_d;
        end
    end

    ifl_slot_ram u_ram (
        .clk_sys  (clk_sys),
        .ce       (ce),
        .wrEn     (wrEn),
        .wrAddr   (wrPtr_q),
        .wrData   (sync2_q[WORD_W-1:0]),
        .rdEn     (phase_q),
        .rdAddr   (rdPtr_q),
        .rdData_q (sampleOut)
    );

    logic sampleValid_d;
    assign sampleValid_d = ce ? phase_q : sampleValid_q;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            sampleValid_q <= 1'b0;
        else
            sampleValid_q <= sampleValid_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers and interrupt
    logic [IRQ_N-1:0] stat_q, stat_d, mask_q, mask_d, events;
    logic [REG_W-1:0] regRdData_d;

    assign events = {syncEdge, frameEdge, fallErr, riseErr};
    assign irq    = |(stat_q & mask_q);

    always_comb
    begin
        ctrl_d = ctrl_q;
        stat_d = stat_q;
        mask_d = mask_q;
        if (regWr && regAddr == OFS_PAR_CTRL)
        begin
            ctrl_d[BIT_PAR_EN]   = regWrData[BIT_PAR_EN];
            ctrl_d[BIT_PAR_EVEN] = regWrData[BIT_PAR_EVEN];
        end
        if (parClear)
        begin
            ctrl_d[BIT_RISE_FLAG] = 1'b0;
            ctrl_d[BIT_FALL_FLAG] = 1'b0;
        end
        // sticky flags, set wins over clear
        if (riseErr)
            ctrl_d[BIT_RISE_FLAG] = 1'b1;
        if (fallErr)
            ctrl_d[BIT_FALL_FLAG] = 1'b1;
        if (regWr && regAddr == OFS_IRQ_STAT)
            stat_d = stat_q & ~regWrData[IRQ_N-1:0];
        stat_d = stat_d | events;
        if (regWr && regAddr == OFS_IRQ_MASK)
            mask_d = regWrData[IRQ_N-1:0];
        regRdData_d = regRdData_q;
        if (regRd)
        begin
            case (regAddr)
                OFS_PAR_CTRL:  regRdData_d = {ctrl_q[7:6], 4'h0, ctrl_q[1:0]};
                OFS_RISE_CNT:  regRdData_d = riseCount;
                OFS_FALL_CNT:  regRdData_d = fallCount;
                OFS_IRQ_STAT:  regRdData_d = {4'h0, stat_q};
                OFS_IRQ_MASK:  regRdData_d = {4'h0, mask_q};
                OFS_FIFO_STAT: regRdData_d = {locked_q, frameSeen_q, 3'h0, fill};
                OFS_DEPTH_CFG: regRdData_d = {5'h00, depthCfg_q};
                OFS_REVISION:  regRdData_d = REVISION;
                default:       regRdData_d = 8'h00;
            endcase
        end
    end

    // ce low freezes the bus too: reads return the held value and writes are lost
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            ctrl_q      <= CTRL_RST;
            stat_q      <= '0;
            mask_q      <= MASK_RST[IRQ_N-1:0];
            regRdData_q <= 8'h00;
        end
        else if (ce)
        begin
            ctrl_q      <= ctrl_d;
            stat_q      <= stat_d;
            mask_q      <= mask_d;
            regRdData_q <= regRdData_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    property p_riseSat;
        ce && riseErr && !parClear && riseCount == CNT_MAX |=> riseCount == CNT_MAX;
    endproperty
    a_riseSat: assert property (p_riseSat) else $error("rise count wrapped");

    property p_fallInc;
        ce && fallErr && !parClear && fallCount != CNT_MAX |=> fallCount == 8'($past(fallCount) + 8'h01);
    endproperty
    a_fallInc: assert property (p_fallInc) else $error("fall count missed an error");

    property p_clear;
        ce && parClear && !riseErr && !fallErr |=> riseCount == 8'h00 && fallCount == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left counts nonzero");

    property p_flag;
        ce && riseErr |=> ctrl_q[BIT_RISE_FLAG] [*1] ##0 (!ce || ctrl_q[BIT_RISE_FLAG]);
    endproperty
    a_flag: assert property (p_flag) else $error("rise flag not set");

    property p_wrap;
        ce && wrEn && wrPtr_q == 3'h7 |=> wrPtr_q == 3'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("write pointer did not wrap");

    property p_depth;
        ce && syncEdge |=> fill == $past(depthCfg_q);
    endproperty
    a_depth: assert property (p_depth) else $error("depth not forced on sync");

    property p_halfRate;
        ce && phase_q && !syncEdge ##1 ce |-> !phase_q;
    endproperty
    a_halfRate: assert property (p_halfRate) else $error("read tick not half rate");

    property p_rdAdvance;
        ce && phase_q && !syncEdge |=> rdPtr_q == 3'($past(rdPtr_q) + 3'h1);
    endproperty
    a_rdAdvance: assert property (p_rdAdvance) else $error("read pointer stalled");

    property p_irq;
        ce && |(events & mask_d) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("masked-in event gave no interrupt");

    property p_lock;
        ce && syncEdge && frameSeen_q |=> locked_q;
    endproperty
    a_lock: assert property (p_lock) else $error("not locked after sync");

    property p_riseInc;
        ce && riseErr && !parClear && riseCount != CNT_MAX |=> riseCount == 8'($past(riseCount) + 8'h01);
    endproperty
    a_riseInc: assert property (p_riseInc) else $error("rise count missed an error");

    property p_fallSat;
        ce && fallErr && !parClear && fallCount == CNT_MAX |=> fallCount == CNT_MAX;
    endproperty
    a_fallSat: assert property (p_fallSat) else $error("fall count wrapped");

    property p_fallFlag;
        ce && fallErr |=> ctrl_q[BIT_FALL_FLAG];
    endproperty
    a_fallFlag: assert property (p_fallFlag) else $error("fall flag not set");

    property p_rdWrap;
        ce && phase_q && !syncEdge && rdPtr_q == 3'h7 |=> rdPtr_q == 3'h0;
    endproperty
    a_rdWrap: assert property (p_rdWrap) else $error("read pointer did not wrap");

    property p_frameReset;
        ce && frameEdge |=> wrPtr_q == 3'h0;
    endproperty
    a_frameReset: assert property (p_frameReset) else $error("frame edge left write pointer");

    property p_wrAdvance;
        ce && wrEn |=> wrPtr_q == 3'($past(wrPtr_q) + 3'h1);
    endproperty
    a_wrAdvance: assert property (p_wrAdvance) else $error("write pointer stalled");

    property p_freeze;
        !ce |=> $stable(wrPtr_q) && $stable(rdPtr_q) && $stable(phase_q) && $stable(riseCount);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

    c_riseSat: cover property (ce && riseErr && riseCount == CNT_MAX);
    c_sync:    cover property (ce && frameEdge ##[1:50] ce && syncEdge);
    c_irq:     cover property (irq);
    c_wrap:    cover property (ce && wrEn && wrPtr_q == 3'h7);
endmodule // ifl_input_fifo
`default_nettype wire

// ==== ifl_data_source.sv ====
// behavioural word source standing at the far side of the input FIFO
`timescale 1ns/1ps
`default_nettype none
module ifl_data_source
    import ifl_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              run,
    input  wire logic              evenMode,
    input  wire logic              badRise,
    input  wire logic              badFall,
    output logic                   wordClk,
    output logic      [WORD_W-1:0] word,
    output logic                   parity
);
    logic              half;
    logic [WORD_W-1:0] cnt;

    initial
    begin
        wordClk = 1'b0;
        word    = 16'h0000;
        parity  = 1'b0;
        half    = 1'b0;
        cnt     = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////
    always @(posedge clk_sys)
    begin
        if (!run)
        begin
            // word clock stands still; idle data keeps moving so a stray capture shows
            word <= ~word;
        end
        else
        begin
            half <= ~half;
            if (half)
            begin
                wordClk <= ~wordClk;
                word    <= cnt;
                cnt     <= cnt + 16'h0001;
                parity  <= (evenMode ? ^cnt : ~^cnt) ^ (wordClk ? badFall : badRise);
            end
        end
    end
endmodule // ifl_data_source
`default_nettype wire

// ==== ifl_input_fifo_test.sv ====
// self-checking bench for the input FIFO and parity counters
`timescale 1ns/1ps
`default_nettype none
module ifl_input_fifo_test
    import ifl_pkg::*;
;
    logic              clk_sys = 1'b0;
    logic              reset_n = 1'b0;
    logic              frameRef = 1'b0;
    logic              syncRef = 1'b0;
    logic              regWr = 1'b0;
    logic              regRd = 1'b0;
    logic              run = 1'b0;
    logic              evenMode = 1'b0;
    logic              badRise = 1'b0;
    logic              badFall = 1'b0;
    logic              chkOrder = 1'b0;
    logic              ce = 1'b1;
    logic [7:0]        regAddr = 8'h00;
    logic [REG_W-1:0]  regWrData = 8'h00;
    logic [REG_W-1:0]  regRdData_q;
    logic [WORD_W-1:0] dataIn;
    logic [WORD_W-1:0] sampleOut;
    logic [WORD_W-1:0] prevOut;
    logic              parityIn;
    logic              inputWordClock;
    logic              sampleValid_q;
    logic              readTick;
    logic              irq;
    logic [15:0]       l2;
    logic [15:0]       l4;
    logic [15:0]       l7;
    int                errors = 0;
    int                total_checks = 0;
    logic [7:0]        rstAddr [8] = '{OFS_PAR_CTRL, OFS_RISE_CNT, OFS_FALL_CNT, OFS_IRQ_STAT,
                                       OFS_IRQ_MASK, OFS_DEPTH_CFG, OFS_REVISION, 8'h00};
    logic [7:0]        rstVal [8]  = '{CTRL_RST, CNT_RST, CNT_RST, 8'h00,
                                       MASK_RST, {5'h00, DEPTH_RST}, REVISION_DEF, 8'h00};

    always #5 clk_sys = ~clk_sys;

    ifl_input_fifo i_ifl_input_fifo (
        .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .inputWordClock(inputWordClock),
        .dataIn(dataIn), .parityIn(parityIn), .frameRef(frameRef), .syncRef(syncRef),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData_q(regRdData_q), .sampleOut(sampleOut), .sampleValid_q(sampleValid_q),
        .readTick(readTick), .irq(irq));

    ifl_data_source i_ifl_data_source (
        .clk_sys(clk_sys), .run(run), .evenMode(evenMode), .badRise(badRise),
        .badFall(badFall), .wordClk(inputWordClock), .word(dataIn), .parity(parityIn));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge clk_sys);
        regWr     <= 1'b0;
        #1;
    endtask

    // masked read: fill bits of the fifo status move every tick
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        @(posedge clk_sys);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk_sys);
        regRd   <= 1'b0;
        #1;
        chk(16'(regRdData_q & m), 16'(e));
    endtask

    task automatic errs(input logic r, input logic f, input int n);
        badRise <= r;
        badFall <= f;
        repeat (n) @(posedge clk_sys);
        badRise <= 1'b0;
        badFall <= 1'b0;
        repeat (10) @(posedge clk_sys);
    endtask

    // sync is launched at a fixed phase of the word clock so latencies compare exactly
    task automatic measure(input logic [2:0] d, output logic [15:0] l);
        chkOrder = 1'b0;
        wr(OFS_DEPTH_CFG, {5'h00, d});
        @(posedge inputWordClock);
        @(posedge clk_sys);
        syncRef <= 1'b1;
        repeat (4) @(posedge clk_sys);
        syncRef <= 1'b0;
        repeat (20) @(posedge clk_sys);
        do
        begin
            @(posedge clk_sys);
            #1;
        end
        while (sampleValid_q !== 1'b1);
        l = dataIn - sampleOut;
        chkOrder = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////
    always @(posedge clk_sys)
    begin
        #1;
        if (sampleValid_q === 1'b1)
        begin
            chk(16'(readTick), 16'h0000);
            if (chkOrder)
                chk(sampleOut, prevOut + 16'h0001);
            prevOut = sampleOut;
        end
    end

    initial
    begin
        #200000;
        errors++;
        complete_run;
    end

    initial
    begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd(rstAddr[i], rstVal[i]);
        chk(16'(irq), 16'h0000);
        wr(OFS_RISE_CNT, 8'h55);
        rd(OFS_RISE_CNT, CNT_RST);
        wr(OFS_DEPTH_CFG, 8'h00);
        rd(OFS_DEPTH_CFG, {5'h00, DEPTH_RST});
        run <= 1'b1;
        @(posedge inputWordClock);
        @(posedge clk_sys);
        frameRef <= 1'b1;
        repeat (4) @(posedge clk_sys);
        frameRef <= 1'b0;
        measure(3'h4, l4);
        rd(OFS_FIFO_STAT, 8'hC0, 8'hC0);
        rd(OFS_IRQ_STAT, 8'h0C, 8'h0C);
        measure(3'h2, l2);
        measure(3'h7, l7);
        chk(l4 - l2, 16'h0002);
        chk(l7 - l4, 16'h0003);
        measure(3'h4, l2);
        chk(l2, l4);
        wr(OFS_IRQ_STAT, 8'h0F);
        wr(OFS_PAR_CTRL, 8'hA0);
        errs(1'b1, 1'b0, 20);
        rd(OFS_RISE_CNT, 8'h05);
        rd(OFS_FALL_CNT, 8'h00);
        rd(OFS_PAR_CTRL, 8'h81);
        rd(OFS_IRQ_STAT, 8'h01);
        chk(16'(irq), 16'h0000);
        wr(OFS_IRQ_MASK, 8'h01);
        chk(16'(irq), 16'h0001);
        errs(1'b0, 1'b1, 20);
        rd(OFS_FALL_CNT, 8'h05);
        rd(OFS_RISE_CNT, 8'h05);
        rd(OFS_PAR_CTRL, 8'h83);
        wr(OFS_IRQ_STAT, 8'h01);
        chk(16'(irq), 16'h0000);
        wr(OFS_IRQ_MASK, 8'h02);
        chk(16'(irq), 16'h0001);
        wr(OFS_IRQ_STAT, 8'h02);
        chk(16'(irq), 16'h0000);
        errs(1'b1, 1'b1, 1100);
        rd(OFS_RISE_CNT, CNT_MAX);
        rd(OFS_FALL_CNT, CNT_MAX);
        wr(OFS_PAR_CTRL, 8'hA0);
        rd(OFS_RISE_CNT, CNT_RST);
        rd(OFS_FALL_CNT, CNT_RST);
        rd(OFS_PAR_CTRL, 8'h80);
        evenMode <= 1'b1;
        wr(OFS_PAR_CTRL, 8'hC0);
        repeat (10) @(posedge clk_sys);
        wr(OFS_PAR_CTRL, 8'hE0);
        repeat (40) @(posedge clk_sys);
        rd(OFS_RISE_CNT, CNT_RST);
        rd(OFS_FALL_CNT, CNT_RST);
        // words are lost while frozen, so the order check stays off from here
        chkOrder = 1'b0;
        @(posedge clk_sys);
        ce <= 1'b0;
        wr(OFS_IRQ_MASK, 8'h0F);
        rd(OFS_IRQ_MASK, 8'h00);
        @(posedge clk_sys);
        ce <= 1'b1;
        rd(OFS_IRQ_MASK, 8'h02);
        complete_run;
    end
endmodule // ifl_input_fifo_test
`default_nettype wire
